/* core/qpm_pkg.sv */
`default_nettype none
package qpm_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned WIN_STEP_US     = 1000;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * WIN_STEP_US;
  localparam int unsigned TICK_W          = 16;

  // ==========================================================
  // window and counter widths
  localparam int unsigned     WIN_W      = 19;
  localparam logic [WIN_W-1:0] WIN_MIN_MS = 19'h00001;
  localparam logic [WIN_W-1:0] WIN_MAX_MS = 19'h41EB0;
  localparam int unsigned     REF_W      = 36;
  localparam int unsigned     CYC_W      = 36;
  localparam int unsigned     FRAC_STD   = 8;
  localparam int unsigned     FRAC_HI    = 16;
  localparam int unsigned     DVD_W      = REF_W + FRAC_HI;
  localparam int unsigned     PER_W      = DVD_W;
  localparam int unsigned     DCNT_W     = 6;
  localparam logic [DCNT_W-1:0] DIV_STEPS = 6'h34;
  localparam int unsigned     NCH        = 2;
  localparam int unsigned     CH_T       = 0;
  localparam int unsigned     CH_P       = 1;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    OP_PRESS = 3'b000,
    OP_TEMP  = 3'b001,
    OP_PPER  = 3'b010,
    OP_TPER  = 3'b011,
    OP_STOP  = 3'b100,
    OP_READ  = 3'b101
  } cmd_op_t;

  typedef enum logic [1:0] {
    SAMP_SINGLE = 2'b00,
    SAMP_CONT   = 2'b01,
    SAMP_HOLD   = 2'b10
  } samp_t;

  typedef enum logic [1:0] {
    INT_SEQ    = 2'b00,
    INT_SIMUL  = 2'b01,
    INT_SEQSIM = 2'b10
  } integ_t;

  typedef enum logic [1:0] {
    CH_IDLE  = 2'b00,
    CH_ARM   = 2'b01,
    CH_GATE  = 2'b10,
    CH_CLOSE = 2'b11
  } ch_state_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_MEAS = 3'b001,
    S_WAIT = 3'b010,
    S_DIV  = 3'b011,
    S_DONE = 3'b100
  } seq_state_t;

  typedef struct packed {
    cmd_op_t            kind;
    logic               hires;
    logic [PER_W-1:0]   press_per;
    logic [PER_W-1:0]   temp_per;
  } result_t;

endpackage
`default_nettype wire

/* core/result_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface result_if;
  import qpm_pkg::*;
  logic    valid;
  logic    ready;
  result_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* core/result_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer; head entry drives the output straight from flops
module result_buffer (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  result_if.snk     in_if,
  result_if.src     out_if
);
  import qpm_pkg::*;

  result_t e0_q;
  result_t e0_d;
  result_t e1_q;
  result_t e1_d;
  logic    v0_q;
  logic    v0_d;
  logic    v1_q;
  logic    v1_d;
  logic    push;
  logic    pop;

  assign in_if.ready  = ~v1_q;
  assign out_if.valid = v0_q;
  assign out_if.data  = e0_q;
  assign push         = in_if.valid & ~v1_q;
  assign pop          = v0_q & out_if.ready;

  always_comb begin
    e0_d = e0_q;
    e1_d = e1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop) begin
      if (v1_q) begin
        e0_d = e1_q;
        v1_d = 1'b0;
      end else begin
        v0_d = 1'b0;
      end
    end
    if (push) begin
      if (!v0_d) begin
        e0_d = in_if.data;
        v0_d = 1'b1;
      end else begin
        e1_d = in_if.data;
        v1_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      e0_q <= '0;
      e1_q <= '0;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end else begin
      e0_q <= e0_d;
      e1_q <= e1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
    end
  end
endmodule
`default_nettype wire

/* core/quartz_period_measurement_core.sv */
// Function
// - two square-wave inputs, pressure and temperature; their periods are measured
// - each period counted over a gated window like a frequency counter
// - window length 0.001 to 270 s in 0.001 s steps
// - pressure and temperature keep separate window settings
// - pressure request measures both periods, then delivers compensation inputs
// - temperature request measures only the temperature period
// - raw period request delivers the selected period uncompensated
// - integration mode starts a measurement per command, answers when done
// - fetch mode measures in background, answers at once with latest result
// - sequential: temperature window first, pressure window after it ends
// - simultaneous: both windows run concurrently
// - sequential simulation: concurrent windows, delivery delayed to sequential timing
// - single sampling: one result per command; dropped in integration mode while a continuous stream runs
// - continuous sampling repeats results until a stop command
// - sample-and-hold stores result; a read command returns it
// - high-resolution mode selectable by the hi_res_i input, sampled when a measurement starts
// - serial frame 8N1 is handled by the host link outside this core
`timescale 1ns/1ps
`default_nettype none
module quartz_period_measurement_core #(
  parameter int unsigned MS_TICK_CYCLES = qpm_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       press_sig_i,
  input  wire logic                       temp_sig_i,
  input  wire logic [qpm_pkg::WIN_W-1:0]  press_window_ms_i,
  input  wire logic [qpm_pkg::WIN_W-1:0]  temp_window_ms_i,
  input  wire logic                       fetch_mode_select_i,
  input  wire logic                       hi_res_i,
  input  wire qpm_pkg::integ_t            integ_mode_i,
  input  wire logic                       cmd_valid_i,
  input  wire qpm_pkg::cmd_op_t           cmd_op_i,
  input  wire qpm_pkg::samp_t             cmd_samp_i,
  output logic                            cmd_ready_o,
  output logic                            res_valid_o,
  input  wire logic                       res_ready_i,
  output qpm_pkg::result_t                res_data_o,
  output logic                            hold_valid_o,
  output logic                            busy_o
);
  import qpm_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [WIN_W-1:0] clamp_win(input logic [WIN_W-1:0] w);
    if (w < WIN_MIN_MS) begin
      return WIN_MIN_MS;
    end
    if (w > WIN_MAX_MS) begin
      return WIN_MAX_MS;
    end
    return w;
  endfunction

  function automatic logic [NCH-1:0] need_of(input cmd_op_t op);
    logic [NCH-1:0] n;
    n = '0;
    n[CH_T] = (op != OP_PPER);
    n[CH_P] = (op == OP_PRESS) || (op == OP_PPER);
    return n;
  endfunction

  function automatic result_t fmt_result(input cmd_op_t op, input logic hr,
                                         input logic [PER_W-1:0] pp,
                                         input logic [PER_W-1:0] tp);
    result_t r;
    r.kind      = op;
    r.hires     = hr;
    r.press_per = ((op == OP_PRESS) || (op == OP_PPER)) ? pp : '0;
    r.temp_per  = (op != OP_PPER) ? tp : '0;
    return r;
  endfunction

  // ==========================================================
  // per-channel gated counters
  ch_state_t         ch_st_q  [NCH];
  ch_state_t         ch_st_d  [NCH];
  logic [WIN_W-1:0]  win_q    [NCH];
  logic [WIN_W-1:0]  win_d    [NCH];
  logic [WIN_W-1:0]  ms_q     [NCH];
  logic [WIN_W-1:0]  ms_d     [NCH];
  logic [TICK_W-1:0] sub_q    [NCH];
  logic [TICK_W-1:0] sub_d    [NCH];
  logic [REF_W-1:0]  ref_q    [NCH];
  logic [REF_W-1:0]  ref_d    [NCH];
  logic [CYC_W-1:0]  cyc_q    [NCH];
  logic [CYC_W-1:0]  cyc_d    [NCH];
  logic [REF_W-1:0]  cref_q   [NCH];
  logic [REF_W-1:0]  cref_d   [NCH];
  logic [CYC_W-1:0]  ccyc_q   [NCH];
  logic [CYC_W-1:0]  ccyc_d   [NCH];
  logic [NCH-1:0]    sig_q;
  logic [NCH-1:0]    sig_now;
  logic [NCH-1:0]    rise;
  logic [NCH-1:0]    done_q;
  logic [NCH-1:0]    done_d;
  logic [NCH-1:0]    start_q;
  logic [NCH-1:0]    start_d;

  assign sig_now[CH_T] = temp_sig_i;
  assign sig_now[CH_P] = press_sig_i;
  assign rise          = sig_now & ~sig_q;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_st_d[c] = ch_st_q[c];
      win_d[c]   = win_q[c];
      ms_d[c]    = ms_q[c];
      sub_d[c]   = sub_q[c];
      ref_d[c]   = ref_q[c];
      cyc_d[c]   = cyc_q[c];
      cref_d[c]  = cref_q[c];
      ccyc_d[c]  = ccyc_q[c];
      done_d[c]  = 1'b0;
      unique case (ch_st_q[c])
        CH_IDLE: begin
          if (start_q[c]) begin
            // each channel latches its own setting, clamped to the legal range
            win_d[c]   = clamp_win((c == CH_P) ? press_window_ms_i : temp_window_ms_i);
            ch_st_d[c] = CH_ARM;
          end
        end
        CH_ARM: begin
          // gate opens on an input edge so only whole input cycles are counted
          if (rise[c]) begin
            ch_st_d[c] = CH_GATE;
            ms_d[c]    = '0;
            sub_d[c]   = '0;
            ref_d[c]   = '0;
            cyc_d[c]   = '0;
          end
        end
        CH_GATE: begin
          ref_d[c] = ref_q[c] + 1'b1;
          if (rise[c]) begin
            cyc_d[c] = cyc_q[c] + 1'b1;
          end
          if (sub_q[c] == TICK_W'(MS_TICK_CYCLES - 1)) begin
            sub_d[c] = '0;
            ms_d[c]  = ms_q[c] + 1'b1;
            if ((ms_q[c] + 1'b1) == win_q[c]) begin
              ch_st_d[c] = CH_CLOSE;
            end
          end else begin
            sub_d[c] = sub_q[c] + 1'b1;
          end
        end
        CH_CLOSE: begin
          ref_d[c] = ref_q[c] + 1'b1;
          if (rise[c]) begin
            cref_d[c]  = ref_q[c] + 1'b1;
            ccyc_d[c]  = cyc_q[c] + 1'b1;
            done_d[c]  = 1'b1;
            ch_st_d[c] = CH_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sig_q  <= '0;
      done_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        ch_st_q[c] <= CH_IDLE;
        win_q[c]   <= WIN_MIN_MS;
        ms_q[c]    <= '0;
        sub_q[c]   <= '0;
        ref_q[c]   <= '0;
        cyc_q[c]   <= '0;
        cref_q[c]  <= '0;
        ccyc_q[c]  <= '0;
      end
    end else begin
      sig_q  <= sig_now;
      done_q <= done_d;
      for (int c = 0; c < NCH; c++) begin
        ch_st_q[c] <= ch_st_d[c];
        win_q[c]   <= win_d[c];
        ms_q[c]    <= ms_d[c];
        sub_q[c]   <= sub_d[c];
        ref_q[c]   <= ref_d[c];
        cyc_q[c]   <= cyc_d[c];
        cref_q[c]  <= cref_d[c];
        ccyc_q[c]  <= ccyc_d[c];
      end
    end
  end

  // ==========================================================
  // sequencer, shared divider and result stores
  seq_state_t        st_q;
  seq_state_t        st_d;
  cmd_op_t           op_q;
  cmd_op_t           op_d;
  samp_t             samp_q;
  samp_t             samp_d;
  logic              cont_q;
  logic              cont_d;
  logic              bg_q;
  logic              bg_d;
  logic              hires_q;
  logic              hires_d;
  logic [NCH-1:0]    need_q;
  logic [NCH-1:0]    need_d;
  logic [NCH-1:0]    got_q;
  logic [NCH-1:0]    got_d;
  logic [TICK_W-1:0] sim_sub_q;
  logic [TICK_W-1:0] sim_sub_d;
  logic [WIN_W:0]    sim_ms_q;
  logic [WIN_W:0]    sim_ms_d;
  logic [WIN_W:0]    sim_tgt_q;
  logic [WIN_W:0]    sim_tgt_d;
  logic              div_ch_q;
  logic              div_ch_d;
  logic [DCNT_W-1:0] div_cnt_q;
  logic [DCNT_W-1:0] div_cnt_d;
  logic [DVD_W-1:0]  dvd_q;
  logic [DVD_W-1:0]  dvd_d;
  logic [CYC_W:0]    rem_q;
  logic [CYC_W:0]    rem_d;
  logic [CYC_W:0]    rem_s;
  logic [PER_W-1:0]  per_q   [NCH];
  logic [PER_W-1:0]  per_d   [NCH];
  logic [PER_W-1:0]  snap_p_q;
  logic [PER_W-1:0]  snap_p_d;
  logic [PER_W-1:0]  snap_t_q;
  logic [PER_W-1:0]  snap_t_d;
  logic              snap_hr_q;
  logic              snap_hr_d;
  result_t           hold_q;
  result_t           hold_d;
  logic              hold_v_q;
  logic              hold_v_d;
  result_t           reply_q;
  result_t           reply_d;
  logic              rpend_q;
  logic              rpend_d;
  logic              cmd_rdy_q;
  logic              cmd_rdy_d;
  logic              busy_q;
  logic              busy_d;
  logic              cmd_take;
  logic              cmd_reply;
  logic              slot_free;
  logic              go_meas;
  cmd_op_t           go_op;
  result_t           done_res;

  result_if buf_in ();
  result_if buf_out ();

  // back-pressure from the buffer stalls the sequencer in S_DONE
  assign buf_in.valid  = rpend_q;
  assign buf_in.data   = reply_q;
  assign slot_free     = ~rpend_q | buf_in.ready;
  // a command arrives as one whole word; character framing stays in the host link
  assign cmd_take      = cmd_valid_i & cmd_rdy_q;
  assign done_res      = fmt_result(op_q, hires_q, per_q[CH_P], per_q[CH_T]);
  assign buf_out.ready = res_ready_i;
  assign res_valid_o   = buf_out.valid;
  assign res_data_o    = buf_out.data;
  assign cmd_ready_o   = cmd_rdy_q;
  assign hold_valid_o  = hold_v_q;
  assign busy_o        = busy_q;

  result_buffer result_buffer_inst (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .in_if     (buf_in),
    .out_if    (buf_out)
  );

  always_comb begin
    st_d = st_q;   op_d = op_q;   samp_d = samp_q;   cont_d = cont_q;
    bg_d = bg_q;   hires_d = hires_q;   need_d = need_q;   got_d = got_q;
    sim_sub_d = sim_sub_q;   sim_ms_d = sim_ms_q;   sim_tgt_d = sim_tgt_q;
    div_ch_d = div_ch_q;   div_cnt_d = div_cnt_q;   dvd_d = dvd_q;   rem_d = rem_q;
    per_d = per_q;   snap_p_d = snap_p_q;   snap_t_d = snap_t_q;   snap_hr_d = snap_hr_q;
    hold_d = hold_q;   hold_v_d = hold_v_q;   reply_d = reply_q;
    rpend_d = rpend_q & ~buf_in.ready;
    start_d = '0;
    go_meas = 1'b0;
    go_op = OP_PRESS;
    cmd_reply = 1'b0;
    rem_s = {rem_q[CYC_W-1:0], dvd_q[DVD_W-1]};

    if (cmd_take) begin
      if (cmd_op_i == OP_STOP) begin
        cont_d = 1'b0;
      end else if (cmd_op_i == OP_READ) begin
        reply_d   = hold_q;
        cmd_reply = 1'b1;
      end else if (fetch_mode_select_i) begin
        unique case (cmd_samp_i)
          SAMP_SINGLE: begin
            reply_d   = fmt_result(cmd_op_i, snap_hr_q, snap_p_q, snap_t_q);
            cmd_reply = 1'b1;
          end
          SAMP_CONT: begin
            op_d   = cmd_op_i;
            cont_d = 1'b1;
          end
          SAMP_HOLD: begin
            hold_d   = fmt_result(cmd_op_i, snap_hr_q, snap_p_q, snap_t_q);
            hold_v_d = 1'b1;
          end
          default: ;
        endcase
      end else if (st_q == S_IDLE) begin
        go_meas = 1'b1;
        go_op   = cmd_op_i;
        op_d    = cmd_op_i;
        samp_d  = cmd_samp_i;
        cont_d  = (cmd_samp_i == SAMP_CONT);
        bg_d    = 1'b0;
      end
      // in integration mode, measurement commands during a running continuous stream are dropped
    end
    if (cmd_reply) begin
      rpend_d = 1'b1;
    end

    unique case (st_q)
      S_IDLE: begin
        if (fetch_mode_select_i && !go_meas) begin
          go_meas = 1'b1;
          go_op   = OP_PRESS;
          bg_d    = 1'b1;
        end
      end
      S_MEAS, S_WAIT: begin
        got_d = got_q | done_q;
        if (done_q[CH_T] && need_q[CH_P] && (integ_mode_i == INT_SEQ)) begin
          start_d[CH_P] = 1'b1;
        end
        if (sim_sub_q == TICK_W'(MS_TICK_CYCLES - 1)) begin
          sim_sub_d = '0;
          sim_ms_d  = sim_ms_q + 1'b1;
        end else begin
          sim_sub_d = sim_sub_q + 1'b1;
        end
        if ((got_d & need_q) == need_q) begin
          if ((integ_mode_i == INT_SEQSIM) && (sim_ms_q < sim_tgt_q)) begin
            st_d = S_WAIT;
          end else begin
            st_d      = S_DIV;
            div_ch_d  = need_q[CH_T] ? 1'(CH_T) : 1'(CH_P);
            div_cnt_d = '0;
          end
        end
      end
      S_DIV: begin
        if (div_cnt_q == '0) begin
          dvd_d     = DVD_W'(cref_q[div_ch_q]) << (hires_q ? FRAC_HI : FRAC_STD);
          rem_d     = '0;
          div_cnt_d = DIV_STEPS;
        end else begin
          if (rem_s >= {1'b0, ccyc_q[div_ch_q]}) begin
            rem_d = rem_s - {1'b0, ccyc_q[div_ch_q]};
            dvd_d = {dvd_q[DVD_W-2:0], 1'b1};
          end else begin
            rem_d = rem_s;
            dvd_d = {dvd_q[DVD_W-2:0], 1'b0};
          end
          div_cnt_d = div_cnt_q - 1'b1;
          if (div_cnt_q == 6'h01) begin
            per_d[div_ch_q] = dvd_d;
            if ((div_ch_q == 1'(CH_T)) && need_q[CH_P]) begin
              div_ch_d = 1'(CH_P);
            end else begin
              st_d = S_DONE;
            end
          end
        end
      end
      S_DONE: begin
        if (bg_q) begin
          // both periods and the mode flag change in the same cycle
          snap_p_d  = per_q[CH_P];
          snap_t_d  = per_q[CH_T];
          snap_hr_d = hires_q;
          if (cont_q && fetch_mode_select_i) begin
            if (slot_free && !cmd_reply) begin
              reply_d = fmt_result(op_q, hires_q, per_q[CH_P], per_q[CH_T]);
              rpend_d = 1'b1;
              st_d    = S_IDLE;
            end
          end else begin
            st_d = S_IDLE;
          end
        end else if (samp_q == SAMP_HOLD) begin
          hold_d   = done_res;
          hold_v_d = 1'b1;
          st_d     = S_IDLE;
        end else if (slot_free && !cmd_reply) begin
          reply_d = done_res;
          rpend_d = 1'b1;
          st_d    = S_IDLE;
          if (cont_q) begin
            go_meas = 1'b1;
            go_op   = op_q;
          end
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase

    if (go_meas) begin
      st_d      = S_MEAS;
      need_d    = need_of(go_op);
      got_d     = '0;
      hires_d   = hi_res_i;
      sim_sub_d = '0;
      sim_ms_d  = '0;
      sim_tgt_d = (need_of(go_op) == 2'h3) ?
                  ({1'b0, clamp_win(temp_window_ms_i)} + {1'b0, clamp_win(press_window_ms_i)})
                  : '0;
      start_d   = need_of(go_op);
      if ((integ_mode_i == INT_SEQ) && (need_of(go_op) == 2'h3)) begin
        start_d = '0;
        start_d[CH_T] = 1'b1;
      end
    end

    busy_d    = (st_d != S_IDLE);
    cmd_rdy_d = ~rpend_d & (fetch_mode_select_i | (st_d == S_IDLE) | cont_d);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= S_IDLE;   op_q <= OP_PRESS;   samp_q <= SAMP_SINGLE;
      cont_q <= 1'b0;   bg_q <= 1'b0;   hires_q <= 1'b0;
      need_q <= '0;   got_q <= '0;   start_q <= '0;
      sim_sub_q <= '0;   sim_ms_q <= '0;   sim_tgt_q <= '0;
      div_ch_q <= 1'b0;   div_cnt_q <= '0;   dvd_q <= '0;   rem_q <= '0;
      per_q[CH_T] <= '0;   per_q[CH_P] <= '0;
      snap_p_q <= '0;   snap_t_q <= '0;   snap_hr_q <= 1'b0;
      hold_q <= '0;   hold_v_q <= 1'b0;   reply_q <= '0;   rpend_q <= 1'b0;
      cmd_rdy_q <= 1'b0;   busy_q <= 1'b0;
    end else begin
      st_q <= st_d;   op_q <= op_d;   samp_q <= samp_d;
      cont_q <= cont_d;   bg_q <= bg_d;   hires_q <= hires_d;
      need_q <= need_d;   got_q <= got_d;   start_q <= start_d;
      sim_sub_q <= sim_sub_d;   sim_ms_q <= sim_ms_d;   sim_tgt_q <= sim_tgt_d;
      div_ch_q <= div_ch_d;   div_cnt_q <= div_cnt_d;   dvd_q <= dvd_d;   rem_q <= rem_d;
      per_q <= per_d;
      snap_p_q <= snap_p_d;   snap_t_q <= snap_t_d;   snap_hr_q <= snap_hr_d;
      hold_q <= hold_d;   hold_v_q <= hold_v_d;   reply_q <= reply_d;   rpend_q <= rpend_d;
      cmd_rdy_q <= cmd_rdy_d;   busy_q <= busy_d;
    end
  end
endmodule
`default_nettype wire

/* verif/quartz_period_measurement_core_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module quartz_period_measurement_core_checker
  import qpm_pkg::*;
(
  input wire logic             sys_clk_i,
  input wire logic             reset_n_i,
  input wire logic             fetch_mode_select_i,
  input wire logic             cmd_valid_i,
  input wire qpm_pkg::cmd_op_t cmd_op_i,
  input wire qpm_pkg::samp_t   cmd_samp_i,
  input wire logic             cmd_ready_o,
  input wire logic             res_valid_o,
  input wire logic             res_ready_i,
  input wire qpm_pkg::result_t res_data_o,
  input wire logic             hold_valid_o,
  input wire logic             busy_o
);
  // ==========================================================
  // port properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire take = cmd_valid_i && cmd_ready_o && cmd_samp_i == SAMP_SINGLE;
  ready_reset_a: assert property (!$past(reset_n_i) |-> !cmd_ready_o)
    else $error("command ready high right after reset");
  outs_reset_a: assert property (!$past(reset_n_i)
    |-> !res_valid_o && !hold_valid_o && !busy_o)
    else $error("outputs active right after reset");
  res_hold_a: assert property (res_valid_o && !res_ready_i
    |=> res_valid_o && $stable(res_data_o))
    else $error("stalled result word changed or vanished");
  fetch_answer_a: assert property (fetch_mode_select_i && take && cmd_op_i <= OP_TPER
    |-> ##2 res_valid_o)
    else $error("fetch reply not two cycles after command");
  busy_start_a: assert property (!fetch_mode_select_i && take && cmd_op_i <= OP_TPER
    |=> busy_o)
    else $error("integration command did not start measurement");
  temp_unused_a: assert property (res_valid_o && res_data_o.kind inside {OP_TEMP, OP_TPER}
    |-> res_data_o.press_per == '0)
    else $error("temperature result carries pressure period");
  pper_unused_a: assert property (res_valid_o && res_data_o.kind == OP_PPER
    |-> res_data_o.temp_per == '0)
    else $error("pressure period result carries temperature period");
  kind_legal_a: assert property (res_valid_o |-> res_data_o.kind <= OP_TPER)
    else $error("result word with non-measurement kind");
  hold_sticky_a: assert property ($rose(hold_valid_o) |=> hold_valid_o[*3])
    else $error("held result flag dropped");
endmodule
`default_nettype wire

/* verif/host_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// result receiver of the host; stalls on command to exercise the buffer
module host_sink
  import qpm_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             stall_i,
  input  wire logic             res_valid_i,
  input  wire qpm_pkg::result_t res_data_i,
  output logic                  res_ready_o,
  output int                    count_o,
  output qpm_pkg::result_t      last_o
);
  assign res_ready_o = !stall_i;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= 0;
      last_o  <= '0;
    end else if (res_valid_i && res_ready_o) begin
      count_o <= count_o + 1;
      last_o  <= res_data_i;
    end
  end
endmodule
`default_nettype wire

/* verif/quartz_period_measurement_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
module quartz_period_measurement_core_test;
  import qpm_pkg::*;
  logic clk = 0, rst_n = 0, press_sig = 0, temp_sig = 0, fetch = 0, hires = 0;
  logic cmd_valid = 0, cmd_ready, res_valid, res_ready, hold_valid, busy, stall = 0;
  integ_t integ = INT_SEQ;
  cmd_op_t cmd_op = OP_TEMP;
  samp_t cmd_samp = SAMP_SINGLE;
  result_t res_data, last;
  int n_rx, err_count = 0, n_compared = 0, pc = 0, tc = 0;
  initial forever #10 clk = ~clk;
  // periods: pressure 6 cycles, temperature 4 cycles
  always @(posedge clk) begin
    pc <= (pc == 5) ? 0 : pc + 1;
    tc <= (tc == 3) ? 0 : tc + 1;
    press_sig <= pc < 3;
    temp_sig <= tc < 2;
  end
  quartz_period_measurement_core #(.MS_TICK_CYCLES(10)) quartz_period_measurement_core_inst (
    .sys_clk_i(clk), .reset_n_i(rst_n), .press_sig_i(press_sig), .temp_sig_i(temp_sig),
    .press_window_ms_i(19'h00003), .temp_window_ms_i(19'h00002), .fetch_mode_select_i(fetch),
    .hi_res_i(hires), .integ_mode_i(integ), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
    .cmd_samp_i(cmd_samp), .cmd_ready_o(cmd_ready), .res_valid_o(res_valid),
    .res_ready_i(res_ready), .res_data_o(res_data), .hold_valid_o(hold_valid), .busy_o(busy));
  host_sink host_sink_inst (.sys_clk_i(clk), .reset_n_i(rst_n), .stall_i(stall),
    .res_valid_i(res_valid), .res_data_i(res_data), .res_ready_o(res_ready),
    .count_o(n_rx), .last_o(last));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chkres(input cmd_op_t k, input logic [51:0] pp, input logic [51:0] tp);
    chk("kind", 52'(k), 52'(last.kind));
    chk("press_per", pp, last.press_per);
    chk("temp_per", tp, last.temp_per);
  endtask
  // holds the request until the edge that samples ready high
  task automatic cmd(input cmd_op_t op, input samp_t sm);
    int i;
    i = 0;
    cmd_op <= op;
    cmd_samp <= sm;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1 && i++ < 3000);
    cmd_valid <= 1'b0;
    chk("cmd_ready", 1, cmd_ready);
  endtask
  task automatic wait_word();
    int c, i;
    c = n_rx;
    i = 0;
    while (n_rx == c && i++ < 3000) @(posedge clk);
    chk("word", 1, n_rx != c);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_temp();
    cmd(OP_TEMP, SAMP_SINGLE);
    wait_word();
    chkres(OP_TEMP, 0, 52'h400);
    repeat (300) @(posedge clk);
    chk("single", 1, n_rx);
    $display("t_temp done");
  endtask
  task automatic t_press();
    for (int m = 0; m < 3; m++) begin
      integ <= integ_t'(m);
      hires <= m[0];
      @(posedge clk);
      cmd(OP_PRESS, SAMP_SINGLE);
      wait_word();
      chkres(OP_PRESS, 52'h6 << (m[0] ? 16 : 8), 52'h4 << (m[0] ? 16 : 8));
      chk("hires", 52'(m[0]), 52'(last.hires));
    end
    hires <= 1'b0;
    cmd(OP_PPER, SAMP_SINGLE);
    wait_word();
    chkres(OP_PPER, 52'h600, 0);
    $display("t_press done");
  endtask
  task automatic t_hold();
    int c, i;
    c = n_rx;
    i = 0;
    cmd(OP_TEMP, SAMP_HOLD);
    while (hold_valid !== 1'b1 && i++ < 3000) @(posedge clk);
    chk("hold_valid", 1, hold_valid);
    chk("no_word", c, n_rx);
    cmd(OP_READ, SAMP_SINGLE);
    wait_word();
    chkres(OP_TEMP, 0, 52'h400);
    $display("t_hold done");
  endtask
  task automatic t_cont();
    int c;
    c = n_rx;
    stall <= 1'b1;
    cmd(OP_TPER, SAMP_CONT);
    repeat (800) @(posedge clk);
    chk("stalled_valid", 1, res_valid);
    chk("stalled_count", c, n_rx);
    stall <= 1'b0;
    cmd(OP_STOP, SAMP_SINGLE);
    repeat (400) @(posedge clk);
    chk("kept_words", 1, n_rx > c + 2);
    chkres(OP_TPER, 0, 52'h400);
    c = n_rx;
    repeat (400) @(posedge clk);
    chk("stopped", c, n_rx);
    $display("t_cont done");
  endtask
  task automatic t_fetch();
    int c;
    fetch <= 1'b1;
    integ <= INT_SIMUL;
    repeat (400) @(posedge clk);
    c = n_rx;
    cmd(OP_PPER, SAMP_SINGLE);
    repeat (3) @(posedge clk);
    #1;
    chk("fetch_fast", c + 1, n_rx);
    chkres(OP_PPER, 52'h600, 0);
    @(posedge clk);
    c = n_rx;
    cmd(OP_PRESS, SAMP_CONT);
    repeat (500) @(posedge clk);
    chk("fetch_cont", 1, n_rx > c + 1);
    chkres(OP_PRESS, 52'h600, 52'h400);
    cmd(OP_STOP, SAMP_SINGLE);
    @(posedge clk);
    cmd(OP_PRESS, SAMP_HOLD);
    @(posedge clk);
    cmd(OP_READ, SAMP_SINGLE);
    wait_word();
    chkres(OP_PRESS, 52'h600, 52'h400);
    $display("t_fetch done");
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_temp();
    t_press();
    t_hold();
    t_cont();
    t_fetch();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
bind quartz_period_measurement_core quartz_period_measurement_core_checker chk_inst (
  .sys_clk_i, .reset_n_i, .fetch_mode_select_i, .cmd_valid_i, .cmd_op_i, .cmd_samp_i,
  .cmd_ready_o, .res_valid_o, .res_ready_i, .res_data_o, .hold_valid_o, .busy_o);
`default_nettype wire
